// file: rtl/remote_temp_defs.svh
/*
 * Register addresses, field positions and reset values of the remote
 * temperature limit, result and offset registers.
 * Assumes a serial front end that presents decoded byte accesses.
 */
`ifndef REMOTE_TEMP_DEFS_SVH
`define REMOTE_TEMP_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define RD_REMOTE_LOW_LIMIT_INT   8'h08
`define WR_REMOTE_LOW_LIMIT_INT   8'h0e
`define WR_SINGLE_CONV_TRIGGER    8'h0f
`define RD_REMOTE_RESULT_FRACTION 8'h10
`define RW_REMOTE_OFFSET_INT      8'h11
`define RW_REMOTE_OFFSET_FRACTION 8'h12
`define RD_REMOTE_RESULT_INT      8'h01

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define FRAC_MSB                  7
`define FRAC_LSB                  4
`define FRAC_PAD                  4'h0
`define BYTE_RESET                8'h00
`define WORD_RESET                12'h000
`define UNMAPPED_READ             8'h00

`endif

// file: rtl/remote_temp_limit_offset_regs.sv
/*
 * Remote low limit, one-shot trigger, remote result with byte
 * coherency lock, and remote offset correction.
 * Assumes host accesses arrive as one-cycle strobes synchronous to
 * sys_clk, and that the converter pulses conv.done once per result.
 */
`include "remote_temp_defs.svh"

// Function
// - Hold eight-bit remote low limit integer, compare remote result against it.
// - Low limit reads at 08h, writes at 0Eh, resets to zero.
// - In shutdown, any write to trigger starts one conversion, data ignored.
// - Trigger at 0Fh is write-only, nothing readable behind it.
// - Result fraction read-only, bits 7..4 sixteenths, low bits read zero.
// - Result fraction readable at 10h, not writable, resets to zero.
// - Each finished conversion overwrites result bytes unless byte is locked.
// - Reading result integer locks fraction until fraction is read.
// - Reading fraction first locks integer until integer is read.
// - Any other register read releases the lock.
// - Hold eight-bit offset integer and add it before storing result.
// - Four offset fraction bits 7..4 join the same addition.
// - Offset shares result format and applies after every conversion.
// - Offset integer at 11h, fraction at 12h, both reset to zero.
// - Shutdown entered only when control bit set, after current conversion.
module remote_temp_limit_offset_regs
(
	// Clock, reset, enable
	input  wire logic                         sys_clk,
	input  wire logic                         nrst,
	input  wire logic                         clk_en,
	// Host register access
	input  wire remote_temp_pkg::host_access_s host,
	output logic      [7:0]                   host_rdata,
	// Converter link
	input  wire remote_temp_pkg::conv_result_s conv,
	input  wire logic                         conv_busy,
	input  wire logic                         shutdown_control_bit,
	output logic                              conv_start,
	output logic                              conv_enable,
	// Unit outputs
	output logic                              in_shutdown,
	output logic                              remote_below_low,
	output logic      [7:0]                   remote_result_int
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	remote_temp_pkg::regs_s r_r;
	remote_temp_pkg::regs_s r_nxt;
	logic [11:0]            corrected;
	logic                   trig_wr;

	function automatic logic is_read(input remote_temp_pkg::host_access_s a, input logic [7:0] addr);
		is_read = a.rd && (a.addr == addr);
	endfunction

	function automatic logic is_write(input remote_temp_pkg::host_access_s a, input logic [7:0] addr);
		is_write = a.wr && (a.addr == addr);
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		r_nxt     = r_r;
		// Wraps on overflow, same as the converter's own format
		corrected = conv.value + {r_r.offset_int, r_r.offset_frac};
		trig_wr   = is_write(host, `WR_SINGLE_CONV_TRIGGER);

		if (is_write(host, `WR_REMOTE_LOW_LIMIT_INT))
		begin
			r_nxt.low_limit_int = host.wdata;
		end
		if (is_write(host, `RW_REMOTE_OFFSET_INT))
		begin
			r_nxt.offset_int = host.wdata;
		end
		if (is_write(host, `RW_REMOTE_OFFSET_FRACTION))
		begin
			r_nxt.offset_frac = host.wdata[`FRAC_MSB:`FRAC_LSB];
		end

		// Conversion store, lock-aware
		if (conv.done)
		begin
			if (r_r.lock != remote_temp_pkg::LOCK_INT)
			begin
				r_nxt.result_int = corrected[11:4];
			end
			if (r_r.lock != remote_temp_pkg::LOCK_FRAC)
			begin
				r_nxt.result_frac = corrected[3:0];
			end
		end

		// Read data and lock tracking; a locked byte keeps stale data by design
		if (host.rd)
		begin
			unique case (host.addr)
				`RD_REMOTE_LOW_LIMIT_INT:   r_nxt.rdata = r_r.low_limit_int;
				`RD_REMOTE_RESULT_INT:      r_nxt.rdata = r_r.result_int;
				`RD_REMOTE_RESULT_FRACTION: r_nxt.rdata = {r_r.result_frac, `FRAC_PAD};
				`RW_REMOTE_OFFSET_INT:      r_nxt.rdata = r_r.offset_int;
				`RW_REMOTE_OFFSET_FRACTION: r_nxt.rdata = {r_r.offset_frac, `FRAC_PAD};
				default:                    r_nxt.rdata = `UNMAPPED_READ;
			endcase
			if (is_read(host, `RD_REMOTE_RESULT_INT))
			begin
				r_nxt.lock = (r_r.lock == remote_temp_pkg::LOCK_INT) ?
				             remote_temp_pkg::LOCK_NONE : remote_temp_pkg::LOCK_FRAC;
			end
			else if (is_read(host, `RD_REMOTE_RESULT_FRACTION))
			begin
				r_nxt.lock = (r_r.lock == remote_temp_pkg::LOCK_FRAC) ?
				             remote_temp_pkg::LOCK_NONE : remote_temp_pkg::LOCK_INT;
			end
			else
			begin
				r_nxt.lock = remote_temp_pkg::LOCK_NONE;
			end
		end

		r_nxt.below_low = (r_nxt.result_int < r_r.low_limit_int);

		// Conversion sequencer
		unique case (r_r.seq)
			remote_temp_pkg::SEQ_CONTINUOUS:
			begin
				// Trigger writes ignored here
				if (shutdown_control_bit)
				begin
					r_nxt.seq = conv_busy ? remote_temp_pkg::SEQ_DRAINING : remote_temp_pkg::SEQ_SHUTDOWN;
				end
			end
			remote_temp_pkg::SEQ_DRAINING:
			begin
				if (!shutdown_control_bit)
				begin
					r_nxt.seq = remote_temp_pkg::SEQ_CONTINUOUS;
				end
				else if (!conv_busy || conv.done)
				begin
					r_nxt.seq = remote_temp_pkg::SEQ_SHUTDOWN;
				end
			end
			remote_temp_pkg::SEQ_SHUTDOWN:
			begin
				if (!shutdown_control_bit)
				begin
					r_nxt.seq = remote_temp_pkg::SEQ_CONTINUOUS;
				end
				else if (trig_wr)
				begin
					r_nxt.seq = remote_temp_pkg::SEQ_ONE_SHOT;
				end
			end
			remote_temp_pkg::SEQ_ONE_SHOT:
			begin
				if (conv.done)
				begin
					r_nxt.seq = shutdown_control_bit ?
					            remote_temp_pkg::SEQ_SHUTDOWN : remote_temp_pkg::SEQ_CONTINUOUS;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			r_r.low_limit_int <= `BYTE_RESET;
			r_r.offset_int    <= `BYTE_RESET;
			r_r.offset_frac   <= `FRAC_PAD;
			r_r.result_int    <= `BYTE_RESET;
			r_r.result_frac   <= `FRAC_PAD;
			r_r.lock          <= remote_temp_pkg::LOCK_NONE;
			r_r.seq           <= remote_temp_pkg::SEQ_CONTINUOUS;
			r_r.rdata         <= `BYTE_RESET;
			r_r.below_low     <= 1'b0;
		end
		else if (clk_en)
		begin
			r_r <= r_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Start pulse is combinational so the converter sees it in the write cycle
	assign conv_start        = clk_en && trig_wr && (r_r.seq == remote_temp_pkg::SEQ_SHUTDOWN)
	                           && shutdown_control_bit;
	assign conv_enable       = (r_r.seq == remote_temp_pkg::SEQ_CONTINUOUS);
	assign in_shutdown       = (r_r.seq == remote_temp_pkg::SEQ_SHUTDOWN);
	assign host_rdata        = r_r.rdata;
	assign remote_below_low  = r_r.below_low;
	assign remote_result_int = r_r.result_int;

endmodule

// file: rtl/remote_temp_pkg.sv
/*
 * Types shared by the remote temperature register block.
 * Assumes the defines header is included where constants are needed.
 */
package remote_temp_pkg;

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		SEQ_CONTINUOUS = 2'h0,
		SEQ_DRAINING   = 2'h1,
		SEQ_SHUTDOWN   = 2'h3,
		SEQ_ONE_SHOT   = 2'h2
	} seq_state_e;

	// ----------------------------------------------------------------
	// Host access and converter result carriers
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} host_access_s;

	typedef struct packed
	{
		logic        done;
		logic [11:0] value;
	} conv_result_s;

	typedef enum logic [1:0]
	{
		LOCK_NONE = 2'h0,
		LOCK_FRAC = 2'h1,
		LOCK_INT  = 2'h2
	} lock_e;

	typedef struct packed
	{
		logic [7:0]  low_limit_int;
		logic [7:0]  offset_int;
		logic [3:0]  offset_frac;
		logic [7:0]  result_int;
		logic [3:0]  result_frac;
		lock_e       lock;
		seq_state_e  seq;
		logic [7:0]  rdata;
		logic        below_low;
	} regs_s;

endpackage

// file: verif/remote_temp_conv_model.sv
/* Converter model: busy for three cycles per start, done pulsing in the third.
   Assumes kick is sampled on the rising edge of sys_clk. */
module remote_temp_conv_model
(
	// Clock and reset
	input wire logic                  sys_clk,
	input wire logic                  nrst,
	// Start and raw value
	input wire logic                  kick,
	input wire logic [11:0]           raw,
	// Result
	output remote_temp_pkg::conv_result_s conv,
	output logic                      conv_busy
);
	logic [1:0] cnt_r;
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
			cnt_r <= 2'h0;
		else if (kick && cnt_r == 2'h0)
			cnt_r <= 2'h3;
		else if (cnt_r != 2'h0)
			cnt_r <= cnt_r - 2'h1;
	assign conv_busy = cnt_r != 2'h0;
	// Inverted outside the done cycle so a stale value never looks valid
	assign conv = {cnt_r == 2'h1, (cnt_r == 2'h1) ? raw : ~raw};
endmodule

// file: verif/remote_temp_limit_offset_regs_tb.sv
/* Register-level bench of the remote limit, result and offset block.
   Assumes the converter model answers three cycles after a start. */
module remote_temp_limit_offset_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0, nrst = 1'b0, go = 1'b0, shutdown_control_bit = 1'b0, clk_en = 1'b1;
	logic [11:0] raw = 12'h000;
	remote_temp_pkg::host_access_s host = '0;
	remote_temp_pkg::conv_result_s conv;
	logic conv_busy, conv_start, conv_enable, in_shutdown, remote_below_low;
	logic [7:0] host_rdata, remote_result_int;
	logic [7:0] rst_addr [4] = '{8'h08, 8'h10, 8'h11, 8'h12};
	int bad_count = 0, cmp_count = 0, cyc = 0;
	remote_temp_limit_offset_regs u_remote_temp_limit_offset_regs (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
		.host(host), .host_rdata(host_rdata), .conv(conv), .conv_busy(conv_busy), .conv_start(conv_start),
		.shutdown_control_bit(shutdown_control_bit), .conv_enable(conv_enable), .in_shutdown(in_shutdown),
		.remote_below_low(remote_below_low), .remote_result_int(remote_result_int));
	remote_temp_conv_model u_remote_temp_conv_model (.sys_clk(sys_clk), .nrst(nrst), .kick(go | conv_start),
		.raw(raw), .conv(conv), .conv_busy(conv_busy));
	task tally_and_finish;
		if (bad_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		host <= '{1'b0, 1'b1, a, d};
		@(posedge sys_clk);
		host.wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge sys_clk);
		host <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge sys_clk);
		host.rd <= 1'b0;
		@(negedge sys_clk);
		chk(n, host_rdata, e);
	endtask
	// Model takes go one edge late, result lands three edges after
	task conv_run(input logic [11:0] r);
		@(posedge sys_clk);
		raw <= r;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	initial forever #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			bad_count++;
			tally_and_finish;
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		foreach (rst_addr[i]) rd(rst_addr[i], 8'h00, "reset");
		chk("enable", {7'h0, conv_enable}, 8'h01);
		wr(8'h0e, 8'h5a);
		wr(8'h08, 8'h11);
		rd(8'h08, 8'h5a, "low limit");
		@(posedge sys_clk);
		clk_en <= 1'b0;
		wr(8'h0e, 8'h77);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		rd(8'h08, 8'h5a, "frozen limit");
		wr(8'h10, 8'hff);
		rd(8'h10, 8'h00, "fraction");
		wr(8'h11, 8'h03);
		wr(8'h12, 8'hf5);
		rd(8'h11, 8'h03, "offset int");
		rd(8'h12, 8'hf0, "offset frac");
		wr(8'h0f, 8'haa);
		@(negedge sys_clk);
		chk("busy", {7'h0, conv_busy}, 8'h00);
		rd(8'h0f, 8'h00, "trigger");
		conv_run(12'h1a2);
		chk("result", remote_result_int, 8'h1e);
		rd(8'h01, 8'h1e, "result int");
		chk("below", {7'h0, remote_below_low}, 8'h01);
		conv_run(12'h2a5);
		chk("result", remote_result_int, 8'h2e);
		rd(8'h10, 8'h10, "held frac");
		conv_run(12'h305);
		rd(8'h10, 8'h40, "frac");
		conv_run(12'h105);
		chk("held int", remote_result_int, 8'h34);
		rd(8'h08, 8'h5a, "low limit");
		conv_run(12'h6a0);
		chk("result", remote_result_int, 8'h6d);
		rd(8'h12, 8'hf0, "offset frac");
		chk("below", {7'h0, remote_below_low}, 8'h00);
		@(posedge sys_clk);
		shutdown_control_bit <= 1'b1;
		raw <= 12'h0c0;
		for (int i = 0; i < 20 && !in_shutdown; i++) @(negedge sys_clk);
		chk("idle", {7'h0, in_shutdown}, 8'h01);
		wr(8'h0f, 8'h00);
		@(negedge sys_clk);
		chk("idle", {7'h0, in_shutdown}, 8'h00);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("idle", {7'h0, in_shutdown}, 8'h01);
		chk("result", remote_result_int, 8'h0f);
		chk("enable", {7'h0, conv_enable}, 8'h00);
		tally_and_finish;
	end
endmodule

// file: verif/remote_temp_regs_properties.sv
/* Port assertions of the remote register block.
   Assumes host strobes last one cycle. */
module remote_temp_regs_chk
(
	input wire logic                           sys_clk,
	input wire logic                           nrst,
	input wire logic                           clk_en,
	input wire remote_temp_pkg::host_access_s host,
	input wire logic [7:0]                     host_rdata,
	input wire remote_temp_pkg::conv_result_s conv,
	input wire logic                           conv_busy,
	input wire logic                           shutdown_control_bit,
	input wire logic                           conv_start,
	input wire logic                           conv_enable,
	input wire logic                           in_shutdown,
	input wire logic                           remote_below_low,
	input wire logic [7:0]                     remote_result_int
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_trig; conv_start |-> in_shutdown && clk_en && host.wr && host.addr == 8'h0f; endproperty
	a_trig: assert property (p_trig) else $error("start without trigger");
	property p_leave; conv_start |=> !in_shutdown; endproperty
	a_leave: assert property (p_leave) else $error("no one-shot run");
	property p_run; !in_shutdown |-> !conv_start; endproperty
	a_run: assert property (p_run) else $error("start while running");
	property p_back; clk_en && conv.done && !in_shutdown && !conv_enable && shutdown_control_bit |=> in_shutdown; endproperty
	a_back: assert property (p_back) else $error("no return to idle");
	property p_sd; $rose(in_shutdown) |-> $past(shutdown_control_bit); endproperty
	a_sd: assert property (p_sd) else $error("idle without control bit");
	property p_sd_off; in_shutdown |-> !conv_enable; endproperty
	a_sd_off: assert property (p_sd_off) else $error("enabled while idle");
	property p_frac; clk_en && host.rd && host.addr == 8'h10 |=> host_rdata[3:0] == 4'h0; endproperty
	a_frac: assert property (p_frac) else $error("fraction low bits set");
	property p_wo; clk_en && host.rd && host.addr == 8'h0f |=> host_rdata == 8'h00; endproperty
	a_wo: assert property (p_wo) else $error("trigger readable");
	property p_lock; clk_en && host.rd && host.addr == 8'h10 ##1 !host.rd |=> $stable(remote_result_int); endproperty
	a_lock: assert property (p_lock) else $error("integer not held");
endmodule
bind remote_temp_limit_offset_regs remote_temp_regs_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
	.host(host), .host_rdata(host_rdata), .conv(conv), .conv_busy(conv_busy), .conv_start(conv_start),
	.shutdown_control_bit(shutdown_control_bit), .conv_enable(conv_enable), .in_shutdown(in_shutdown),
	.remote_below_low(remote_below_low), .remote_result_int(remote_result_int));
